// [src/adcs_pkg.sv]
// package: register map, field positions and state timing of the scan sequencer
package adcs_pkg;
    // ==================================================================
    // register byte offsets
    localparam logic [7:0] ADCS_CSR_OFF = 8'h00; // converter_control_status
    localparam logic [7:0] ADCS_CR_OFF = 8'h04; // converter_control
    localparam logic [7:0] ADCS_RES_OFF = 8'h08; // result_register_a, b..d follow per word
    localparam logic [7:0] ADCS_RES_END = 8'h14; // result_register_d
    // ==================================================================
    // field positions and reset values
    localparam int ADCS_FLAG_BIT = 7; // conversion_end_flag
    localparam int ADCS_IE_BIT = 6; // conversion_end_irq_enable
    localparam int ADCS_START_CONVERSION_BIT_BIT = 5; // start_conversion_bit
    localparam int ADCS_SCAN_BIT = 4; // scan mode select
    localparam int ADCS_CKS_BIT = 3; // conversion_clock_select
    localparam int ADCS_GRP_BIT = 2; // group_select_bit
    localparam int ADCS_TRIGGER_ENABLE_BIT_BIT = 7; // trigger_enable_bit
    localparam logic [7:0] ADCS_CSR_RST = 8'h00;
    localparam logic [6:0] ADCS_CR_FILL = 7'h7F; // reserved bits read as one
    localparam logic [7:0] ADCS_RES_RST = 8'h00;
    localparam logic [7:0] ADCS_SAR_MSB = 8'h80;
    // ==================================================================
    // timing in states; one state is one pclk cycle
    localparam logic [8:0] ADCS_SYNC_MIN_S = 9'h012; // 18
    localparam logic [8:0] ADCS_SYNC_MAX_S = 9'h021; // 33
    localparam logic [8:0] ADCS_SYNC_MIN_F = 9'h00A; // 10
    localparam logic [8:0] ADCS_SYNC_MAX_F = 9'h011; // 17
    localparam logic [8:0] ADCS_SAMPLE_S = 9'h03F; // 63
    localparam logic [8:0] ADCS_SAMPLE_F = 9'h01F; // 31
    localparam logic [8:0] ADCS_SINGLE_MIN_S = 9'h0E3; // 227
    localparam logic [8:0] ADCS_SINGLE_MAX_S = 9'h0F2; // 242
    localparam logic [8:0] ADCS_SINGLE_MIN_F = 9'h073; // 115
    localparam logic [8:0] ADCS_SINGLE_MAX_F = 9'h07A; // 122
    localparam logic [8:0] ADCS_FIRST_MIN_S = 9'h103; // 259
    localparam logic [8:0] ADCS_FIRST_MAX_S = 9'h112; // 274
    localparam logic [8:0] ADCS_FIRST_MIN_F = 9'h083; // 131
    localparam logic [8:0] ADCS_FIRST_MAX_F = 9'h08A; // 138
    localparam logic [8:0] ADCS_NEXT_S = 9'h100; // 256
    localparam logic [8:0] ADCS_NEXT_F = 9'h080; // 128
    // derived segment lengths
    localparam logic [8:0] ADCS_CONV1_S = ADCS_SINGLE_MAX_S - ADCS_SYNC_MAX_S - ADCS_SAMPLE_S;
    localparam logic [8:0] ADCS_CONV1_F = ADCS_SINGLE_MAX_F - ADCS_SYNC_MAX_F - ADCS_SAMPLE_F;
    localparam logic [8:0] ADCS_CONVN_S = ADCS_FIRST_MAX_S - ADCS_SYNC_MAX_S - ADCS_SAMPLE_S;
    localparam logic [8:0] ADCS_CONVN_F = ADCS_FIRST_MAX_F - ADCS_SYNC_MAX_F - ADCS_SAMPLE_F;
    localparam logic [8:0] ADCS_GAP_S = ADCS_NEXT_S - (ADCS_FIRST_MAX_S - ADCS_SYNC_MAX_S);
    localparam logic [8:0] ADCS_GAP_F = ADCS_NEXT_F - (ADCS_FIRST_MAX_F - ADCS_SYNC_MAX_F);
    localparam logic [8:0] ADCS_STEP_MASK_S = 9'h00F; // one approximation per 16 states
    localparam logic [8:0] ADCS_STEP_MASK_F = 9'h007; // one approximation per 8 states
    // ==================================================================
    // carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } adcs_apb_req_type;
    typedef struct packed {
        logic [2:0] channel; // analog input select
        logic sample; // sample-and-hold tracking
        logic [7:0] trial; // code on the comparison dac
    } adcs_analog_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SYNC = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONV = 3'b011,
        ST_GAP = 3'b100
    } adcs_state_type;
endpackage

// [src/adcs_scan_sequencer.sv]
// scan sequencer and apb register file of an eight-channel sar converter
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module adcs_scan_sequencer #(
    parameter int RES_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic standby_req,
    input wire adcs_pkg::adcs_apb_req_type apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_trigger_pin,
    input wire logic comparator_in,
    output adcs_pkg::adcs_analog_type analog,
    output logic conversion_end_interrupt
);
    import adcs_pkg::*;
    // ==================================================================
    // elaboration check
    generate
        if (RES_W != 8)
        begin : g_bad_width
            $error("adcs_scan_sequencer: only an 8-bit result is supported");
        end
    endgenerate
    // ==================================================================
    // declarations
    adcs_state_type state_r, state_nxt; // sequencer state
    logic [8:0] cnt_r, cnt_nxt; // state count inside a segment
    logic [8:0] len_w; // length of the current segment
    logic [3:0] phase_r; // free-running alignment phase
    logic [3:0] ph_r; // phase caught at start
    logic flag_r, flag_nxt; // conversion_end_flag
    logic armed_r; // flag seen set by a read
    logic ie_r, start_conversion_bit_r, start_conversion_bit_nxt, scan_r, cks_r; // control bits
    logic [2:0] ch_r; // group_select_bit and channel selects
    logic trigger_enable_bit_r; // trigger_enable_bit
    logic trig_prev_r; // last trigger pin level
    logic [1:0] idx_r; // channel index within group
    logic [7:0] trial_r, mask_r; // sar code and bit under test
    logic [7:0] res_r [4]; // result registers a..d
    logic [31:0] prdata_r; // registered read data
    logic [7:0] rd_w; // read mux
    logic acc_w, setup_w, wr_csr_w, wr_cr_w, rd_csr_w, hit_w;
    logic [7:0] wdat_w; // low byte of write data
    logic trig_go_w, start_w, abort_w, seg_end_w, conv_done_w;
    logic wr_res_w, last_w, pass_end_w, step_w;
    logic [1:0] res_sel_w; // result register picked
    logic [8:0] sync_len_w, step_mask_w;
    // ==================================================================
    // apb decode
    assign acc_w = apb_req.psel & apb_req.penable;
    assign setup_w = apb_req.psel & ~apb_req.penable;
    assign wdat_w = apb_req.pwdata[7:0];
    assign hit_w = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr <= ADCS_RES_END);
    assign wr_csr_w = acc_w & apb_req.pwrite & (apb_req.paddr == ADCS_CSR_OFF);
    assign wr_cr_w = acc_w & apb_req.pwrite & (apb_req.paddr == ADCS_CR_OFF);
    assign rd_csr_w = acc_w & ~apb_req.pwrite & (apb_req.paddr == ADCS_CSR_OFF);
    // zero-wait slave; an unmapped word answers with an error
    assign pready = 1'b1;
    assign pslverr = acc_w & ~hit_w;
    assign prdata = prdata_r;
    // read mux; results may be read at any time, scan running or not
    assign rd_w = (apb_req.paddr == ADCS_CSR_OFF) ? {flag_r, ie_r, start_conversion_bit_r, scan_r, cks_r, ch_r} :
                  (apb_req.paddr == ADCS_CR_OFF) ? {trigger_enable_bit_r, ADCS_CR_FILL} :
                  (hit_w && apb_req.paddr >= ADCS_RES_OFF) ? res_r[apb_req.paddr[3:2] - 2'h2] :
                  8'h00;
    // read data is caught in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h0000_0000;
        else if (setup_w)
            prdata_r <= {24'h00_0000, rd_w};
    end
    // ==================================================================
    // start, stop and trigger
    // trigger pin is synchronous already, so one flop finds the edge
    assign trig_go_w = trigger_enable_bit_r & trig_prev_r & ~external_trigger_pin;
    assign abort_w = standby_req | (wr_csr_w & ~wdat_w[ADCS_START_CONVERSION_BIT_BIT]);
    // later assignments win: standby, then software write
    always_comb
    begin
        start_conversion_bit_nxt = start_conversion_bit_r;
        if (trig_go_w)
            start_conversion_bit_nxt = 1'b1;
        if (conv_done_w && !scan_r)
            start_conversion_bit_nxt = 1'b0;
        if (wr_csr_w)
            start_conversion_bit_nxt = wdat_w[ADCS_START_CONVERSION_BIT_BIT];
        if (standby_req)
            start_conversion_bit_nxt = 1'b0;
    end
    assign start_w = ~start_conversion_bit_r & start_conversion_bit_nxt;
    // ==================================================================
    // segment lengths
    // sync length follows the phase caught at start: 18..33 or 10..17
    assign sync_len_w = cks_r ? (ADCS_SYNC_MIN_F + {6'h00, ph_r[2:0]}) :
                                (ADCS_SYNC_MIN_S + {5'h00, ph_r});
    assign len_w = (state_r == ST_SYNC) ? sync_len_w :
                   (state_r == ST_SAMPLE) ? (cks_r ? ADCS_SAMPLE_F : ADCS_SAMPLE_S) :
                   (state_r == ST_CONV) ? (scan_r ? (cks_r ? ADCS_CONVN_F : ADCS_CONVN_S) :
                                                    (cks_r ? ADCS_CONV1_F : ADCS_CONV1_S)) :
                   (state_r == ST_GAP) ? (cks_r ? ADCS_GAP_F : ADCS_GAP_S) :
                   9'h000;
    assign seg_end_w = (state_r != ST_IDLE) && (cnt_r == len_w);
    assign conv_done_w = (state_r == ST_CONV) && seg_end_w;
    // a conversion cut off by a stop never reaches a register
    assign wr_res_w = conv_done_w & ~abort_w;
    assign last_w = ~scan_r | (idx_r == ch_r[1:0]);
    assign pass_end_w = wr_res_w & last_w;
    // group one lands in a..d just like group zero
    assign res_sel_w = scan_r ? idx_r : ch_r[1:0];
    // ==================================================================
    // sequencer state
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = seg_end_w ? 9'h001 : cnt_r + 9'h001;
        case (state_r)
            ST_SYNC:
                if (seg_end_w)
                    state_nxt = ST_SAMPLE;
            ST_SAMPLE:
                if (seg_end_w)
                    state_nxt = ST_CONV;
            ST_CONV:
                if (seg_end_w)
                    state_nxt = scan_r ? ST_GAP : ST_IDLE;
            ST_GAP:
                if (seg_end_w)
                    state_nxt = ST_SAMPLE;
            default:
                state_nxt = ST_IDLE;
        endcase
        if (start_w)
        begin
            state_nxt = ST_SYNC;
            cnt_nxt = 9'h001;
        end
        else if (!start_conversion_bit_nxt)
            state_nxt = ST_IDLE;
    end
    // state register and alignment phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 9'h001;
            phase_r <= 4'h0;
            ph_r <= 4'h0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            phase_r <= phase_r + 4'h1;
            if (start_w)
                ph_r <= phase_r;
        end
    end
    // channel index; every start begins at the group's first input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            idx_r <= 2'h0;
        else if (start_w)
            idx_r <= 2'h0;
        else if (wr_res_w && scan_r)
            idx_r <= last_w ? 2'h0 : idx_r + 2'h1;
    end
    // ==================================================================
    // successive approximation
    // steps at every 16th or 8th state of the conversion segment
    assign step_mask_w = cks_r ? ADCS_STEP_MASK_F : ADCS_STEP_MASK_S;
    assign step_w = (state_r == ST_CONV) && (mask_r != 8'h00) && ((cnt_r & step_mask_w) == 9'h000);

    // keep the bit when the input is at or above the trial code
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trial_r <= 8'h00;
            mask_r <= 8'h00;
        end
        else if (state_r == ST_SAMPLE && seg_end_w)
        begin
            trial_r <= ADCS_SAR_MSB;
            mask_r <= ADCS_SAR_MSB;
        end
        else if (step_w)
        begin
            trial_r <= (comparator_in ? trial_r : (trial_r & ~mask_r)) | (mask_r >> 1);
            mask_r <= mask_r >> 1;
        end
    end

    // result registers, one per slot
    generate
        for (genvar g = 0; g < 4; g++)
        begin : g_res
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    res_r[g] <= ADCS_RES_RST;
                else if (wr_res_w && res_sel_w == 2'(g))
                    res_r[g] <= trial_r;
            end
        end
    endgenerate

    // ==================================================================
    // control and status bits
    // hardware set beats a software clear in the same cycle
    always_comb
    begin
        flag_nxt = flag_r;
        if (wr_csr_w && !wdat_w[ADCS_FLAG_BIT] && armed_r)
            flag_nxt = 1'b0;
        if (pass_end_w)
            flag_nxt = 1'b1;
        if (standby_req)
            flag_nxt = 1'b0;
    end

    // settings take effect with the same write that starts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {flag_r, ie_r, start_conversion_bit_r, scan_r, cks_r, ch_r} <= ADCS_CSR_RST;
            trigger_enable_bit_r <= 1'b0;
            armed_r <= 1'b0;
            trig_prev_r <= 1'b1;
        end
        else
        begin
            flag_r <= flag_nxt;
            start_conversion_bit_r <= start_conversion_bit_nxt;
            trig_prev_r <= external_trigger_pin;
            if (standby_req)
            begin
                {ie_r, scan_r, cks_r, ch_r} <= 6'h00;
                trigger_enable_bit_r <= 1'b0;
            end
            else
            begin
                if (wr_csr_w)
                    {ie_r, scan_r, cks_r, ch_r} <= {wdat_w[ADCS_IE_BIT], wdat_w[ADCS_SCAN_BIT:0]};
                if (wr_cr_w)
                    trigger_enable_bit_r <= wdat_w[ADCS_TRIGGER_ENABLE_BIT_BIT];
            end
            // clearing needs a read that saw the flag set
            if (!flag_nxt)
                armed_r <= 1'b0;
            else if (rd_csr_w && flag_r)
                armed_r <= 1'b1;
        end
    end

    // ==================================================================
    // outputs
    assign conversion_end_interrupt = flag_r & ie_r;
    assign analog.channel = scan_r ? {ch_r[ADCS_GRP_BIT], idx_r} : ch_r;
    assign analog.sample = (state_r == ST_SAMPLE);
    assign analog.trial = trial_r;

    // ==================================================================
    // checks
    logic [9:0] tot_r, per_r, smp_r; // states since start, since last result, in sampling
    logic first_r; // first conversion after a start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tot_r <= 10'h000;
            per_r <= 10'h000;
            smp_r <= 10'h000;
            first_r <= 1'b0;
        end
        else
        begin
            tot_r <= start_w ? 10'h001 : tot_r + 10'h001;
            per_r <= conv_done_w ? 10'h001 : per_r + 10'h001;
            smp_r <= analog.sample ? smp_r + 10'h001 : 10'h000;
            if (start_w)
                first_r <= 1'b1;
            else if (conv_done_w)
                first_r <= 1'b0;
        end
    end

    sequence s_start;
        start_w;
    endsequence
    sequence s_fresh_sync;
        state_r == ST_SYNC && cnt_r == 9'h001 && idx_r == 2'h0;
    endsequence

    chk_first_channel: assert property (@(posedge pclk) disable iff (!presetn)
        s_start |=> s_fresh_sync)
        else $error("scan did not restart at first channel");
    chk_sample_len: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(analog.sample) && state_r == ST_CONV |-> smp_r == {1'b0, cks_r ? ADCS_SAMPLE_F : ADCS_SAMPLE_S})
        else $error("sampling window length wrong");
    chk_sync_range: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_SYNC && seg_end_w |-> cnt_r >= (cks_r ? ADCS_SYNC_MIN_F : ADCS_SYNC_MIN_S) &&
        cnt_r <= (cks_r ? ADCS_SYNC_MAX_F : ADCS_SYNC_MAX_S))
        else $error("sync delay out of range");
    chk_single_total: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done_w && !scan_r |-> tot_r >= {1'b0, cks_r ? ADCS_SINGLE_MIN_F : ADCS_SINGLE_MIN_S} &&
        tot_r <= {1'b0, cks_r ? ADCS_SINGLE_MAX_F : ADCS_SINGLE_MAX_S})
        else $error("single conversion time out of range");
    chk_scan_first: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done_w && scan_r && first_r |-> tot_r >= {1'b0, cks_r ? ADCS_FIRST_MIN_F : ADCS_FIRST_MIN_S} &&
        tot_r <= {1'b0, cks_r ? ADCS_FIRST_MAX_F : ADCS_FIRST_MAX_S})
        else $error("first scan conversion time out of range");
    chk_scan_period: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done_w && scan_r && !first_r |-> per_r == {1'b0, cks_r ? ADCS_NEXT_F : ADCS_NEXT_S})
        else $error("scan conversion period wrong");
    chk_single_stop: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done_w && !scan_r && !wr_csr_w && !trig_go_w |=> !start_conversion_bit_r && state_r == ST_IDLE)
        else $error("single mode did not stop");
    chk_pass_flag: assert property (@(posedge pclk) disable iff (!presetn)
        pass_end_w && !standby_req |=> flag_r && (conversion_end_interrupt == ie_r))
        else $error("pass end did not raise flag");
    chk_abort_idle: assert property (@(posedge pclk) disable iff (!presetn)
        start_conversion_bit_r && abort_w |-> !wr_res_w ##1 state_r == ST_IDLE)
        else $error("stop did not abort conversion");
    chk_trigger_go: assert property (@(posedge pclk) disable iff (!presetn)
        trig_go_w && !start_conversion_bit_r && !wr_csr_w && !standby_req |=> start_conversion_bit_r && state_r == ST_SYNC)
        else $error("trigger edge did not start conversion");
    chk_sar_steps: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done_w |-> mask_r == 8'h00)
        else $error("approximation steps incomplete");
    chk_next_channel: assert property (@(posedge pclk) disable iff (!presetn)
        wr_res_w && scan_r && !last_w && start_conversion_bit_nxt |=> state_r == ST_GAP && idx_r == $past(idx_r) + 2'h1)
        else $error("scan did not advance channel");

endmodule
`default_nettype wire

// [verification/adcs_analog_model.sv]
// far-side model: analog inputs held at fixed levels, compared against the trial code
`timescale 1ns/1ps
`default_nettype none
module adcs_analog_model #(
    parameter logic [63:0] LEVELS = 64'h0 // one byte per input, input 7 in the top byte
) (
    input wire adcs_pkg::adcs_analog_type analog,
    output logic comparator_in
);
    import adcs_pkg::*;
    // ==========================================
    // comparator
    // a constant level per input, so every conversion of one input ends in the same code
    wire logic [7:0] level = LEVELS[{analog.channel, 3'h0} +: 8]; // level of the selected input
    assign comparator_in = (level >= analog.trial); // high while input reaches the code
endmodule
`default_nettype wire

// [verification/tb_adc_scan_sequencer.sv]
// self-checking bench of the scan sequencer: registers, timing, scan order, trigger, abort
`timescale 1ns/1ps
`default_nettype none
module tb_adc_scan_sequencer;
    import adcs_pkg::*;
    // ==========================================
    // signals
    localparam logic [63:0] LVL = 64'hFFC4_9A6E_0080_2D17; // levels of inputs 7..0, both ends included
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    adcs_apb_req_type apb_req = '0;
    logic trig = 1'h1; // trigger line idles high
    logic standby = 1'h0; // standby request line
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cmp;
    logic irq;
    adcs_analog_type analog;
    logic [31:0] rd; // word of the last transfer
    logic err; // error of the last transfer
    int cyc = 0; // free-running cycle count
    int t_irq; // cycle at which the interrupt was seen
    int failures = 0;
    int n_compared = 0;
    // clock and cycle count
    always #25 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    // standby is pulsed once, in mid-scan, by its own scenario
    adcs_scan_sequencer #(.RES_W(8)) uut (.pclk(pclk), .presetn(presetn), .standby_req(standby),
        .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_trigger_pin(trig),
        .comparator_in(cmp), .analog(analog), .conversion_end_interrupt(irq));
    adcs_analog_model #(.LEVELS(LVL)) far_side (.analog(analog), .comparator_in(cmp));
    // ==========================================
    // shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rng(input string what, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi)
        begin
            failures++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic wrap_up();
        if (failures == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic hang(input string what);
        failures++;
        $display("[ERR] %s expected done seen timeout", what);
        wrap_up();
    endtask
    // one apb transfer; a clock edge first, so a release never meets the next setup
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int k;
        @(posedge pclk);
        apb_req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge pclk);
        apb_req.penable <= 1'h1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (k >= 20)
            hang("pready");
        rd = prdata;
        err = pslverr;
        apb_req.psel <= 1'h0;
        apb_req.penable <= 1'h0;
    endtask
    task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp, input string what);
        apb(1'h0, addr, 32'h0);
        chk(what, exp, rd);
    endtask
    // cycles from the last write edge until the interrupt shows
    task automatic wait_irq(output int n);
        #1;
        n = 0;
        while (irq !== 1'h1)
        begin
            @(posedge pclk);
            #1;
            n++;
            if (n > 2000)
                hang("interrupt");
        end
        t_irq = cyc;
    endtask
    // next sampling window; the input is judged as the window closes
    task automatic wait_conv(input logic [2:0] ch);
        int k;
        k = 0;
        while (analog.sample !== 1'h1 && k < 400)
        begin
            @(posedge pclk);
            #1;
            k++;
        end
        while (analog.sample !== 1'h0 && k < 400)
        begin
            @(posedge pclk);
            #1;
            k++;
        end
        if (k >= 400)
            hang("sample window");
        chk("sampled input", {29'h0, ch}, {29'h0, analog.channel});
    endtask
    // ==========================================
    // scenarios
    task automatic check_reset();
        rdchk(ADCS_CSR_OFF, 32'h0, "status reset");
        rdchk(ADCS_CR_OFF, 32'h7F, "control reset");
        apb(1'h1, ADCS_RES_OFF, 32'hA5);
        rdchk(ADCS_RES_OFF, 32'h0, "result write ignored");
        apb(1'h0, 8'h18, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
    endtask
    task automatic check_single();
        int n;
        apb(1'h1, ADCS_CSR_OFF, 32'h63);
        wait_irq(n);
        rng("single slow time", 227, 242, n);
        rdchk(ADCS_CSR_OFF, 32'hC3, "single status");
        rdchk(ADCS_RES_END, 32'h0, "low reference code");
        apb(1'h1, ADCS_CSR_OFF, 32'h43);
        rdchk(ADCS_CSR_OFF, 32'h43, "flag cleared");
        apb(1'h1, ADCS_CSR_OFF, 32'h2A);
        n = 0;
        do
        begin
            apb(1'h0, ADCS_CSR_OFF, 32'h0);
            n++;
        end while (rd[7] !== 1'h1 && n < 100);
        chk("masked interrupt", 32'h0, {31'h0, irq});
        chk("fast single status", 32'h8A, rd);
        rdchk(ADCS_RES_OFF + 8'h08, 32'h80, "mid-scale code");
        apb(1'h1, ADCS_CSR_OFF, 32'h0A);
    endtask
    task automatic check_scan();
        int n;
        int t1;
        apb(1'h1, ADCS_CSR_OFF, 32'h7A);
        wait_irq(n);
        rng("first pass fast", 387, 394, n);
        t1 = t_irq;
        rdchk(ADCS_RES_OFF, 32'h17, "result a");
        rdchk(ADCS_RES_OFF + 8'h04, 32'h2D, "result b");
        rdchk(ADCS_RES_OFF + 8'h08, 32'h80, "result c");
        rdchk(ADCS_CSR_OFF, 32'hFA, "scan keeps running");
        apb(1'h1, ADCS_CSR_OFF, 32'h7A);
        wait_irq(n);
        rng("pass period", 384, 384, t_irq - t1);
    endtask
    task automatic check_trigger();
        int n;
        rdchk(ADCS_CSR_OFF, 32'hFA, "flag before stop");
        apb(1'h1, ADCS_CSR_OFF, 32'h0);
        apb(1'h1, ADCS_CR_OFF, 32'h80);
        rdchk(ADCS_CR_OFF, 32'hFF, "trigger enable");
        apb(1'h1, ADCS_CSR_OFF, 32'h57);
        trig <= 1'h0;
        @(posedge pclk);
        trig <= 1'h1;
        wait_conv(3'h4);
        wait_irq(n);
        wait_conv(3'h4);
        rdchk(ADCS_RES_OFF, 32'h6E, "group one a");
        rdchk(ADCS_RES_OFF + 8'h04, 32'h9A, "group one b");
        rdchk(ADCS_RES_OFF + 8'h08, 32'hC4, "group one c");
        rdchk(ADCS_RES_END, 32'hFF, "high reference code");
        apb(1'h1, ADCS_CSR_OFF, 32'h17);
        rdchk(ADCS_RES_OFF, 32'h6E, "aborted result kept");
        apb(1'h1, ADCS_CSR_OFF, 32'h37);
        wait_conv(3'h4);
        apb(1'h1, ADCS_CSR_OFF, 32'h17);
    endtask
    // standby in mid-scan clears control bits and flag, results stay
    task automatic check_standby();
        apb(1'h1, ADCS_CR_OFF, 32'h80);
        apb(1'h1, ADCS_CSR_OFF, 32'h7A);
        wait_conv(3'h0);
        @(posedge pclk);
        standby <= 1'h1;
        @(posedge pclk);
        standby <= 1'h0;
        rdchk(ADCS_CSR_OFF, 32'h0, "standby status");
        rdchk(ADCS_CR_OFF, 32'h7F, "standby control");
        rdchk(ADCS_RES_OFF + 8'h08, 32'hC4, "standby keeps result");
        chk("standby interrupt", 32'h0, {31'h0, irq});
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        check_reset();
        check_single();
        check_scan();
        check_trigger();
        check_standby();
        wrap_up();
    end
endmodule
`default_nettype wire
